// *** rtl/bcrf_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - The privilege flag in the status word selects user or privileged register view.
// - The dsp enable bit in the status word makes accumulator, operand, loop regs usable.
// - Privileged mode with bank select 1 maps registers 0..7 to the second bank.
// - Privileged mode with bank select 0 maps registers 0..7 to the first bank.
// - The unselected bank is reached only by control load and save, never by operands.
// - User mode sees first bank, regs 8..15, global base, mac pair, link and pc.
// - Privileged mode adds saved status, vector base, saved pc and both banks.
// - Register 0 is given out as the index operand for indexed addressing.
// - User mode always maps registers 0..7 to the first bank.
// - Reset sets privilege, bank-select and block flags, mask 1111, reserved bits 0.
// - Sixteen 32-bit general registers are visible.
module bcrf_top #(
  parameter int DW = 32, // Register width
  parameter int GW = 8   // Accumulator guard width
) (
  input  wire logic                ref_clk,     // Core clock
  input  wire logic                srst,        // Sync reset, active high
  input  wire logic [3:0]          rd_a_idx,    // Read port A register number
  input  wire logic [3:0]          rd_b_idx,    // Read port B register number
  input  wire bcrf_pkg::bcrf_wr_t  gwr,         // General register write
  input  wire bcrf_pkg::bcrf_cwr_t cwr,         // Control/system write
  input  wire bcrf_pkg::bcrf_creg_t crd_sel,    // Control/system read select
  input  wire logic [2:0]          crd_bidx,    // Other-bank read index
  input  wire logic                pc_ld,       // Load pc from pc_nxt
  input  wire logic [DW-1:0]       pc_nxt,      // Next program counter
  input  wire logic                acc_wr,      // Accumulator write strobe
  input  wire logic                acc_sel,     // 0 selects acc0, 1 acc1
  input  wire logic [DW+GW-1:0]    acc_data,    // 40-bit accumulator value
  input  wire logic [2:0]          dop_wr_idx,  // Operand reg index M0..Y1
  input  wire logic                dop_wr,      // Operand reg write strobe
  input  wire logic [DW-1:0]       dop_data,    // Operand reg write data
  output logic      [DW-1:0]       rd_a_data,   // Read port A data
  output logic      [DW-1:0]       rd_b_data,   // Read port B data
  output logic      [DW-1:0]       index_data,  // Register 0 index operand
  output logic      [DW-1:0]       crd_data,    // Control/system read data
  output logic      [DW-1:0]       pc_out,      // Program counter
  output logic      [DW-1:0]       status_out,  // Status word
  output logic                     priv_mode,   // Privilege flag
  output logic                     dsp_mode,    // Dsp enable
  output logic      [DW+GW-1:0]    acc0_out,    // Accumulator 0 with guard
  output logic      [DW+GW-1:0]    acc1_out,    // Accumulator 1 with guard
  output logic                     acc_refused  // Dsp write dropped, mode off
);

  logic [DW-1:0]    gpr_ff [24];     // Two banks of 0..7 plus 8..15
  logic [DW-1:0]    nxt_gpr [24];
  logic [DW-1:0]    sw_ff, nxt_sw;
  logic [DW-1:0]    ssw_ff, nxt_ssw, gbase_ff, nxt_gbase, vbase_ff, nxt_vbase;
  logic [DW-1:0]    spc_ff, nxt_spc, mult_acc_high_ff, nxt_mult_acc_high, mult_acc_low_ff, nxt_mult_acc_low;
  logic [DW-1:0]    link_ff, nxt_link, pc_ff, nxt_pc;
  logic [DW-1:0]    lstart_ff, nxt_lstart, lend_ff, nxt_lend, wrap_ff, nxt_wrap;
  logic [DW-1:0]    dsr_ff, nxt_dsr;
  logic [DW-1:0]    dop_ff [6];
  logic [DW-1:0]    nxt_dop [6];
  logic [DW+GW-1:0] acc0_ff, nxt_acc0, acc1_ff, nxt_acc1;
  logic             refused_ff, nxt_refused;
  logic [4:0]       pa_idx, pb_idx, pw_idx, p0_idx;
  logic             priv, bank, dsp;
  logic [4:0]       alt_slot;

  assign priv = sw_ff[bcrf_pkg::SW_PRIV_BIT];
  assign bank = sw_ff[bcrf_pkg::SW_BANK_BIT];
  assign dsp  = sw_ff[bcrf_pkg::SW_DSP_BIT];

  // Same mapper four times: both reads, the write, and the index operand
  bcrf_bank_map u_map_a (.reg_idx(rd_a_idx), .priv(priv), .bank_sel(bank), .phys_idx(pa_idx));
  bcrf_bank_map u_map_b (.reg_idx(rd_b_idx), .priv(priv), .bank_sel(bank), .phys_idx(pb_idx));
  bcrf_bank_map u_map_w (.reg_idx(gwr.idx), .priv(priv), .bank_sel(bank), .phys_idx(pw_idx));
  bcrf_bank_map u_map_0 (.reg_idx(4'h0), .priv(priv), .bank_sel(bank), .phys_idx(p0_idx));

  // Unselected bank slot for control load/save; in user mode there is none
  function automatic logic [4:0] alt_map(input logic [2:0] b, input logic bk);
    alt_map = bk ? {2'b00, b} : {2'b10, b};
  endfunction : alt_map

  function automatic logic priv_only(input bcrf_pkg::bcrf_creg_t s);
    priv_only = (s == bcrf_pkg::BCRF_CR_SSTATUS) || (s == bcrf_pkg::BCRF_CR_VBASE) ||
                (s == bcrf_pkg::BCRF_CR_SPC) || (s == bcrf_pkg::BCRF_CR_ALTBANK) ||
                (s == bcrf_pkg::BCRF_CR_STATUS);
  endfunction : priv_only

  function automatic logic dsp_only(input bcrf_pkg::bcrf_creg_t s);
    dsp_only = (s == bcrf_pkg::BCRF_CR_LSTART) || (s == bcrf_pkg::BCRF_CR_LEND) ||
               (s == bcrf_pkg::BCRF_CR_WRAP) || (s == bcrf_pkg::BCRF_CR_DSR);
  endfunction : dsp_only

  assign alt_slot = alt_map(cwr.bidx, bank);

  // Next-state for the whole register file
  always_comb begin
    nxt_gpr     = gpr_ff;
    nxt_sw      = sw_ff;
    nxt_ssw     = ssw_ff;
    nxt_gbase   = gbase_ff;
    nxt_vbase   = vbase_ff;
    nxt_spc     = spc_ff;
    nxt_mult_acc_high    = mult_acc_high_ff;
    nxt_mult_acc_low    = mult_acc_low_ff;
    nxt_link    = link_ff;
    nxt_pc      = pc_ld ? pc_nxt : pc_ff;
    nxt_lstart  = lstart_ff;
    nxt_lend    = lend_ff;
    nxt_wrap    = wrap_ff;
    nxt_dsr     = dsr_ff;
    nxt_dop     = dop_ff;
    nxt_acc0    = acc0_ff;
    nxt_acc1    = acc1_ff;
    nxt_refused = 1'b0;
    if (gwr.en) begin
      nxt_gpr[pw_idx] = gwr.data;
    end
    // Privileged-only and dsp-only targets are silently dropped otherwise
    if (cwr.en && (priv || !priv_only(cwr.sel)) && (dsp || !dsp_only(cwr.sel))) begin
      case (cwr.sel)
        bcrf_pkg::BCRF_CR_STATUS:  nxt_sw     = cwr.data & bcrf_pkg::SW_WRITE_MASK;
        bcrf_pkg::BCRF_CR_SSTATUS: nxt_ssw    = cwr.data;
        bcrf_pkg::BCRF_CR_GBASE:   nxt_gbase  = cwr.data;
        bcrf_pkg::BCRF_CR_VBASE:   nxt_vbase  = cwr.data;
        bcrf_pkg::BCRF_CR_SPC:     nxt_spc    = cwr.data;
        bcrf_pkg::BCRF_CR_MULT_ACC_HIGH:    nxt_mult_acc_high   = cwr.data;
        bcrf_pkg::BCRF_CR_MULT_ACC_LOW:    nxt_mult_acc_low   = cwr.data;
        bcrf_pkg::BCRF_CR_LINK:    nxt_link   = cwr.data;
        bcrf_pkg::BCRF_CR_PC:      nxt_pc     = cwr.data;
        bcrf_pkg::BCRF_CR_LSTART:  nxt_lstart = cwr.data;
        bcrf_pkg::BCRF_CR_LEND:    nxt_lend   = cwr.data;
        bcrf_pkg::BCRF_CR_WRAP:    nxt_wrap   = cwr.data;
        bcrf_pkg::BCRF_CR_DSR:     nxt_dsr    = cwr.data;
        bcrf_pkg::BCRF_CR_ALTBANK: nxt_gpr[alt_slot] = cwr.data;
        default: ;
      endcase
    end
    if (acc_wr || dop_wr) begin
      if (!dsp) begin
        nxt_refused = 1'b1;
      end else begin
        if (acc_wr && !acc_sel) begin
          nxt_acc0 = acc_data;
        end
        if (acc_wr && acc_sel) begin
          nxt_acc1 = acc_data;
        end
        if (dop_wr && (dop_wr_idx < 3'h6)) begin
          nxt_dop[dop_wr_idx] = dop_data;
        end
      end
    end
  end

  // Register everything; only status, vbase, pc, dsr and the refusal flag have a reset value
  always_ff @(posedge ref_clk) begin
    gpr_ff     <= nxt_gpr;
    ssw_ff     <= nxt_ssw;
    gbase_ff   <= nxt_gbase;
    spc_ff     <= nxt_spc;
    mult_acc_high_ff    <= nxt_mult_acc_high;
    mult_acc_low_ff    <= nxt_mult_acc_low;
    link_ff    <= nxt_link;
    lstart_ff  <= nxt_lstart;
    lend_ff    <= nxt_lend;
    wrap_ff    <= nxt_wrap;
    dop_ff     <= nxt_dop;
    acc0_ff    <= nxt_acc0;
    acc1_ff    <= nxt_acc1;
    if (srst) begin
      sw_ff      <= bcrf_pkg::SW_RESET_VAL;
      vbase_ff   <= bcrf_pkg::VBR_RESET_VAL;
      pc_ff      <= bcrf_pkg::PC_RESET_VAL;
      dsr_ff     <= bcrf_pkg::DSR_RESET_VAL;
      refused_ff <= 1'b0;
    end else begin
      sw_ff      <= nxt_sw;
      vbase_ff   <= nxt_vbase;
      pc_ff      <= nxt_pc;
      dsr_ff     <= nxt_dsr;
      refused_ff <= nxt_refused;
    end
  end

  // Reads: combinational, see last written value after the edge
  assign rd_a_data  = gpr_ff[pa_idx];
  assign rd_b_data  = gpr_ff[pb_idx];
  assign index_data = gpr_ff[p0_idx];

  always_comb begin
    crd_data = '0;
    if ((priv || !priv_only(crd_sel)) && (dsp || !dsp_only(crd_sel))) begin
      case (crd_sel)
        bcrf_pkg::BCRF_CR_STATUS:  crd_data = sw_ff;
        bcrf_pkg::BCRF_CR_SSTATUS: crd_data = ssw_ff;
        bcrf_pkg::BCRF_CR_GBASE:   crd_data = gbase_ff;
        bcrf_pkg::BCRF_CR_VBASE:   crd_data = vbase_ff;
        bcrf_pkg::BCRF_CR_SPC:     crd_data = spc_ff;
        bcrf_pkg::BCRF_CR_MULT_ACC_HIGH:    crd_data = mult_acc_high_ff;
        bcrf_pkg::BCRF_CR_MULT_ACC_LOW:    crd_data = mult_acc_low_ff;
        bcrf_pkg::BCRF_CR_LINK:    crd_data = link_ff;
        bcrf_pkg::BCRF_CR_PC:      crd_data = pc_ff;
        bcrf_pkg::BCRF_CR_LSTART:  crd_data = lstart_ff;
        bcrf_pkg::BCRF_CR_LEND:    crd_data = lend_ff;
        bcrf_pkg::BCRF_CR_WRAP:    crd_data = wrap_ff;
        bcrf_pkg::BCRF_CR_DSR:     crd_data = dsr_ff;
        bcrf_pkg::BCRF_CR_ALTBANK: crd_data = gpr_ff[alt_map(crd_bidx, bank)];
        default:                   crd_data = '0;
      endcase
    end
  end

  assign pc_out      = pc_ff;
  assign status_out  = sw_ff;
  assign priv_mode   = priv;
  assign dsp_mode    = dsp;
  assign acc0_out    = acc0_ff;
  assign acc1_out    = acc1_ff;
  assign acc_refused = refused_ff;

endmodule : bcrf_top

// *** rtl/bcrf_pkg.sv ***
package bcrf_pkg;

  // Status word field positions
  localparam int SW_PRIV_BIT   = 30;
  localparam int SW_BANK_BIT   = 29;
  localparam int SW_BLOCK_BIT  = 28;
  localparam int SW_DSP_BIT    = 12;
  localparam int SW_IMASK_LSB  = 4;
  localparam int SW_IMASK_MSB  = 7;

  // Writable status bits; everything else is reserved and reads zero
  localparam logic [31:0] SW_WRITE_MASK = 32'h7000_13f3;
  localparam logic [31:0] SW_RESET_VAL  = 32'h7000_00f0;
  localparam logic [31:0] VBR_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] PC_RESET_VAL  = 32'ha000_0000;
  localparam logic [31:0] DSR_RESET_VAL = 32'h0000_0000;

  // Control and system register selectors
  typedef enum logic [3:0] {
    BCRF_CR_STATUS  = 4'h0,
    BCRF_CR_SSTATUS = 4'h1,
    BCRF_CR_GBASE   = 4'h2,
    BCRF_CR_VBASE   = 4'h3,
    BCRF_CR_SPC     = 4'h4,
    BCRF_CR_MULT_ACC_HIGH    = 4'h5,
    BCRF_CR_MULT_ACC_LOW    = 4'h6,
    BCRF_CR_LINK    = 4'h7,
    BCRF_CR_PC      = 4'h8,
    BCRF_CR_LSTART  = 4'h9,
    BCRF_CR_LEND    = 4'ha,
    BCRF_CR_WRAP    = 4'hb,
    BCRF_CR_DSR     = 4'hc,
    BCRF_CR_ALTBANK = 4'hd
  } bcrf_creg_t;

  // One write request from the execute stage
  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } bcrf_wr_t;

  // Control/system register access (also load/save of the other bank)
  typedef struct packed {
    logic        en;
    bcrf_creg_t  sel;
    logic [2:0]  bidx;
    logic [31:0] data;
  } bcrf_cwr_t;

endpackage : bcrf_pkg

// *** rtl/bcrf_bank_map.sv ***
`timescale 1ns/1ps
// Maps a general register number onto the physical 24-entry array
module bcrf_bank_map (
  input  wire logic [3:0] reg_idx,  // Register number 0..15
  input  wire logic       priv,     // Privilege flag
  input  wire logic       bank_sel, // Bank-select flag
  output logic      [4:0] phys_idx  // Physical slot 0..23
);

  // Slots 0..7 first bank, 8..15 shared high regs, 16..23 second bank
  always_comb begin
    if (reg_idx[3]) begin
      phys_idx = {1'b0, reg_idx};
    end else if (priv && bank_sel) begin
      phys_idx = {2'b10, reg_idx[2:0]};
    end else begin
      phys_idx = {2'b00, reg_idx[2:0]};
    end
  end

endmodule : bcrf_bank_map

// *** dv/bcrf_checker.sv ***
`timescale 1ns/1ps
// Watches reset value, status flags, bank refusal and dsp gating at the top ports
module bcrf_checker #(
  parameter int DW = 32, // Register width
  parameter int GW = 8   // Guard width
) (
  input wire logic                 ref_clk,    // Clock
  input wire logic                 srst,       // Reset
  input wire bcrf_pkg::bcrf_wr_t   gwr,        // General write
  input wire bcrf_pkg::bcrf_cwr_t  cwr,        // Control write
  input wire bcrf_pkg::bcrf_creg_t crd_sel,    // Control read select
  input wire logic                 acc_wr,     // Acc strobe
  input wire logic                 acc_sel,    // Acc select
  input wire logic [DW+GW-1:0]     acc_data,   // Acc data
  input wire logic [DW-1:0]        index_data, // Register 0
  input wire logic [DW-1:0]        crd_data,   // Control read data
  input wire logic [DW-1:0]        status_out, // Status word
  input wire logic                 priv_mode,  // Privilege flag
  input wire logic                 dsp_mode,   // Dsp enable
  input wire logic [DW+GW-1:0]     acc0_out,   // Acc 0
  input wire logic                 acc_refused // Drop pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // An accumulator write attempted while the mode is off
  sequence s_drop; acc_wr && !dsp_mode; endsequence
  // Reset check must run while reset is high, so it overrides the default disable
  property p_rst; disable iff (1'b0) srst |=> status_out == 32'h7000_00f0; endproperty
  property p_rsv; (status_out & ~32'h7000_13f3) == 32'h0; endproperty
  property p_flags; priv_mode == status_out[30] && dsp_mode == status_out[12]; endproperty
  property p_drop; s_drop |=> acc_refused && acc0_out == $past(acc0_out); endproperty
  property p_quiet; !acc_wr |=> !acc_refused; endproperty
  property p_acc; acc_wr && dsp_mode && !acc_sel |=> acc0_out == $past(acc_data); endproperty
  property p_idx; gwr.en && gwr.idx == 4'h0 && !cwr.en |=> index_data == $past(gwr.data); endproperty
  property p_usw; !priv_mode && cwr.en && cwr.sel == bcrf_pkg::BCRF_CR_STATUS |=> $stable(status_out); endproperty
  property p_ualt; !priv_mode && crd_sel == bcrf_pkg::BCRF_CR_ALTBANK |-> crd_data == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("status reset value wrong");
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  a_flags: assert property (p_flags) else $error("mode flags differ from status");
  a_drop: assert property (p_drop) else $error("acc write with dsp off not dropped");
  a_quiet: assert property (p_quiet) else $error("spurious refusal pulse");
  a_acc: assert property (p_acc) else $error("acc0 not 40 bits of write data");
  a_idx: assert property (p_idx) else $error("index operand is not register 0");
  a_usw: assert property (p_usw) else $error("user status write took effect");
  a_ualt: assert property (p_ualt) else $error("other bank readable in user mode");
endmodule : bcrf_checker

bind bcrf_top bcrf_checker #(.DW(DW), .GW(GW)) bcrf_checker_inst (.ref_clk(ref_clk),
  .srst(srst), .gwr(gwr), .cwr(cwr), .crd_sel(crd_sel), .acc_wr(acc_wr), .acc_sel(acc_sel),
  .acc_data(acc_data), .index_data(index_data), .crd_data(crd_data), .status_out(status_out),
  .priv_mode(priv_mode), .dsp_mode(dsp_mode), .acc0_out(acc0_out), .acc_refused(acc_refused));

// *** dv/bcrf_exec_model.sv ***
`timescale 1ns/1ps
// Execute-stage stand-in; each request stands for exactly one cycle
module bcrf_exec_model (
  input  wire logic           ref_clk, // Clock
  output bcrf_pkg::bcrf_wr_t  gwr,     // General write
  output bcrf_pkg::bcrf_cwr_t cwr,     // Control write
  output logic                acc_wr,  // Acc strobe
  output logic                acc_sel, // Acc select
  output logic [39:0]         acc_data // Acc data
);
  // Idle at time zero
  initial begin
    gwr = '0;
    cwr = '0;
    acc_wr = 1'b0;
    acc_sel = 1'b0;
    acc_data = 40'h0;
  end
  // Released fields carry inverted data so a stale value can never match
  task automatic gen_wr(input logic [3:0] i, input logic [31:0] d);
    gwr = '{en: 1'b1, idx: i, data: d};
    @(posedge ref_clk);
    #1 gwr = '{en: 1'b0, idx: ~i, data: ~d};
  endtask : gen_wr
  task automatic ctl_wr(input bcrf_pkg::bcrf_creg_t s, input logic [2:0] b, input logic [31:0] d);
    cwr = '{en: 1'b1, sel: s, bidx: b, data: d};
    @(posedge ref_clk);
    #1 cwr = '{en: 1'b0, sel: s, bidx: ~b, data: ~d};
  endtask : ctl_wr
  task automatic acc_write(input logic sl, input logic [39:0] d);
    acc_wr = 1'b1;
    acc_sel = sl;
    acc_data = d;
    @(posedge ref_clk);
    #1 acc_wr = 1'b0;
    acc_data = ~d;
  endtask : acc_write
endmodule : bcrf_exec_model

// *** dv/bcrf_top_tb.sv ***
`timescale 1ns/1ps
module bcrf_top_tb;
  typedef struct { logic [39:0] exp; int kind; string nm; } bcrf_note_t;
  localparam bcrf_pkg::bcrf_creg_t ST = bcrf_pkg::BCRF_CR_STATUS;
  localparam bcrf_pkg::bcrf_creg_t ALT = bcrf_pkg::BCRF_CR_ALTBANK;
  logic                 ref_clk = 1'b0;
  logic                 srst = 1'b1;
  logic [3:0]           rd_a_idx = 4'h0, rd_b_idx = 4'h0;
  bcrf_pkg::bcrf_creg_t crd_sel = ST;
  logic [2:0]           crd_bidx = 3'h0;
  logic                 obs_stb = 1'b0;
  bcrf_pkg::bcrf_wr_t   gwr;
  bcrf_pkg::bcrf_cwr_t  cwr;
  logic                 acc_wr, acc_sel, priv_mode, dsp_mode, acc_refused;
  logic [39:0]          acc_data, acc0_out, acc1_out, acc_v;
  logic [31:0]          rd_a_data, rd_b_data, index_data, crd_data, pc_out, status_out, dz;
  logic [31:0]          d0 [8];
  logic [31:0]          d1 [16];
  integer               seed = 64448;
  int                   error_cnt = 0, check_count = 0, cyc = 0;
  bcrf_note_t           notes [$];
  bcrf_note_t           n;
  always #2.5 ref_clk = ~ref_clk;
  bcrf_exec_model exec_inst (.ref_clk(ref_clk), .gwr(gwr), .cwr(cwr), .acc_wr(acc_wr),
    .acc_sel(acc_sel), .acc_data(acc_data));
  bcrf_top bcrf_top_inst (.ref_clk(ref_clk), .srst(srst), .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx), .gwr(gwr), .cwr(cwr), .crd_sel(crd_sel), .crd_bidx(crd_bidx),
    .pc_ld(1'b0), .pc_nxt(32'h0), .acc_wr(acc_wr), .acc_sel(acc_sel), .acc_data(acc_data),
    .dop_wr_idx(3'h0), .dop_wr(1'b0), .dop_data(32'h0), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .index_data(index_data), .crd_data(crd_data), .pc_out(pc_out),
    .status_out(status_out), .priv_mode(priv_mode), .dsp_mode(dsp_mode), .acc0_out(acc0_out),
    .acc1_out(acc1_out), .acc_refused(acc_refused));
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic cmp40(input string nm, input logic [39:0] e, input logic [39:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp40
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp32
  task automatic cmp1(input string nm, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask : cmp1
  // Sets read selects for one cycle and leaves a note for the monitor
  task automatic look(input int k, input logic [3:0] ri, input bcrf_pkg::bcrf_creg_t cs,
                      input logic [2:0] bi, input logic [39:0] e, input string nm);
    rd_a_idx = ri;
    rd_b_idx = ~ri;
    crd_sel = cs;
    crd_bidx = bi;
    notes.push_back('{e, k, nm});
    obs_stb = 1'b1;
    step();
    obs_stb = 1'b0;
  endtask : look
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Compare at the falling edge, once reads and registered pulses have settled
  always @(negedge ref_clk) begin
    if (obs_stb) begin
      n = notes.pop_front();
      case (n.kind)
        0: cmp32(n.nm, n.exp[31:0], rd_a_data);
        1: cmp32(n.nm, n.exp[31:0], crd_data);
        2: cmp32(n.nm, n.exp[31:0], status_out);
        3: cmp40(n.nm, n.exp, acc0_out);
        5: cmp32(n.nm, n.exp[31:0], pc_out);
        6: cmp32(n.nm, n.exp[31:0], rd_b_data);
        7: cmp40(n.nm, n.exp, acc1_out);
        default: cmp1(n.nm, n.exp[0], acc_refused);
      endcase
    end
  end
  // Hang guard; the whole run needs only about 125 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (10) step();
    srst = 1'b0;
    look(2, 4'h0, ST, 3'h0, 40'h00_7000_00f0, "status");
    look(5, 4'h0, ST, 3'h0, 40'h00_a000_0000, "pc reset");
    look(1, 4'h0, bcrf_pkg::BCRF_CR_VBASE, 3'h0, 40'h0, "vbase");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      d1[i] = $random(seed);
      exec_inst.gen_wr(4'(i), d1[i]);
      look(0, 4'(i), ST, 3'h0, {8'h00, d1[i]}, "bank1 reg");
    end
    exec_inst.ctl_wr(ST, 3'h0, 32'h5000_00f0);
    for (int i = 0; i < 8; i++) begin
      d0[i] = $random(seed);
      exec_inst.gen_wr(4'(i), d0[i]);
      look(0, 4'(i), ST, 3'h0, {8'h00, d0[i]}, "bank0 reg");
      look(1, 4'h0, ALT, 3'(i), {8'h00, d1[i]}, "other bank");
    end
    dz = $random(seed);
    exec_inst.ctl_wr(ALT, 3'h2, dz);
    look(1, 4'h0, ALT, 3'h2, {8'h00, dz}, "other bank write");
    look(0, 4'h2, ST, 3'h0, {8'h00, d0[2]}, "current bank kept");
    $display("test banks done");
    exec_inst.ctl_wr(ST, 3'h0, 32'h5000_10f0);
    acc_v = {8'ha5, 32'($random(seed))};
    exec_inst.acc_write(1'b0, acc_v);
    look(3, 4'h0, ST, 3'h0, acc_v, "acc0");
    exec_inst.acc_write(1'b1, ~acc_v);
    look(7, 4'h0, ST, 3'h0, ~acc_v, "acc1");
    exec_inst.ctl_wr(ST, 3'h0, 32'h5000_00f0);
    exec_inst.acc_write(1'b0, ~acc_v);
    look(4, 4'h0, ST, 3'h0, 40'h1, "acc refused");
    look(3, 4'h0, ST, 3'h0, acc_v, "acc0 kept");
    $display("test dsp done");
    exec_inst.ctl_wr(ST, 3'h0, 32'h3000_00f0);
    look(2, 4'h0, ST, 3'h0, 40'h00_3000_00f0, "user status");
    // Port B gets the inverted number, so flipping port A's index aims it at reg i
    for (int i = 0; i < 16; i++) begin
      look(0, 4'(i), ST, 3'h0, {8'h00, (i < 8) ? d0[i] : d1[i]}, "user reg");
      look(6, ~4'(i), ST, 3'h0, {8'h00, (i < 8) ? d0[i] : d1[i]}, "user reg b");
    end
    exec_inst.ctl_wr(ST, 3'h0, 32'h7000_00f0);
    look(2, 4'h0, ST, 3'h0, 40'h00_3000_00f0, "user status write");
    look(1, 4'h0, ALT, 3'h0, 40'h0, "user other bank");
    exec_inst.gen_wr(4'h0, ~d0[0]);
    look(0, 4'h0, ST, 3'h0, {8'h00, ~d0[0]}, "user reg0 write");
    $display("test user done");
    // Second reset from user mode must bring back the privileged reset view
    srst = 1'b1;
    repeat (2) step();
    srst = 1'b0;
    look(2, 4'h0, ST, 3'h0, 40'h00_7000_00f0, "status after reset");
    $display("test reset again done");
    summarize();
  end
endmodule : bcrf_top_tb
